// *** shared/pfd_pkg.sv ***
// Purpose: Constants, types and region table for the peripheral frame decoder.
// Assumes: Word (16-bit) addressing of the peripheral space.
// Notes:   Table order matters only for overlaps, and the regions do not overlap.
package pfd_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;

  // Offset bits that select a word inside one PWM register region.
  localparam int PWM_OFS_BITS = 6;
  // Protected words inside each PWM region, one bit per word offset.
  localparam logic [63:0] PWM_PROT_MASK = 64'hffff_0000_0000_0000;

  localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum {FRAME_ZERO, FRAME_ONE, FRAME_TWO} pfd_frame_type;
  typedef enum {PROT_NONE, PROT_UNLOCK, PROT_FLASH, PROT_PWM} pfd_prot_type;
  typedef enum {ST_IDLE, ST_WAIT} pfd_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    pfd_frame_type     frame;
    pfd_prot_type      prot;
    logic              canCtrl;
  } pfd_region_type;

  localparam int REGION_COUNT = 36;

  localparam pfd_region_type REGION_TABLE [REGION_COUNT] = '{
    '{16'h0880, 16'h09ff, FRAME_ZERO, PROT_UNLOCK, 1'b0},
    '{16'h0a80, 16'h0adf, FRAME_ZERO, PROT_FLASH,  1'b0},
    '{16'h0ae0, 16'h0aef, FRAME_ZERO, PROT_UNLOCK, 1'b0},
    '{16'h0b00, 16'h0b0f, FRAME_ZERO, PROT_NONE,   1'b0},
    '{16'h0c00, 16'h0c3f, FRAME_ZERO, PROT_NONE,   1'b0},
    '{16'h0ce0, 16'h0cff, FRAME_ZERO, PROT_NONE,   1'b0},
    '{16'h0d00, 16'h0dff, FRAME_ZERO, PROT_UNLOCK, 1'b0},
    '{16'h6000, 16'h60ff, FRAME_ONE,  PROT_NONE,   1'b1},
    '{16'h6100, 16'h61ff, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6200, 16'h62ff, FRAME_ONE,  PROT_NONE,   1'b1},
    '{16'h6300, 16'h63ff, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6800, 16'h683f, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h6840, 16'h687f, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h6880, 16'h68bf, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h68c0, 16'h68ff, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h6900, 16'h693f, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h6940, 16'h697f, FRAME_ONE,  PROT_PWM,    1'b0},
    '{16'h6a00, 16'h6a1f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6a20, 16'h6a3f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6a40, 16'h6a5f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6a60, 16'h6a7f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6b00, 16'h6b3f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6b40, 16'h6b7f, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6f80, 16'h6fbf, FRAME_ONE,  PROT_UNLOCK, 1'b0},
    '{16'h6fc0, 16'h6fdf, FRAME_ONE,  PROT_NONE,   1'b0},
    '{16'h6fe0, 16'h6fff, FRAME_ONE,  PROT_UNLOCK, 1'b0},
    '{16'h7010, 16'h702f, FRAME_TWO,  PROT_UNLOCK, 1'b0},
    '{16'h7040, 16'h704f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7050, 16'h705f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7070, 16'h707f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7100, 16'h711f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7740, 16'h774f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7750, 16'h775f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7760, 16'h776f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7780, 16'h778f, FRAME_TWO,  PROT_NONE,   1'b0},
    '{16'h7900, 16'h792f, FRAME_TWO,  PROT_NONE,   1'b0}
  };

endpackage : pfd_pkg

// *** shared/pfd_dec_if.sv ***
// Purpose: Carries the region lookup and the unlock state to the decoder core.
// Assumes: One decoder per interface instance.
// Notes:   Purely combinational except for the unlock flag.
`timescale 1ns/100ps
`default_nettype none
interface pfd_dec_if;
  logic [pfd_pkg::ADDR_W-1:0] addr;
  logic                       mapped;
  pfd_pkg::pfd_frame_type     frame;
  pfd_pkg::pfd_prot_type      prot;
  logic                       canCtrl;
  logic                       unlocked;

  modport lookup (input addr, output mapped, output frame, output prot, output canCtrl);
  modport lock   (output unlocked);
  modport core   (output addr, input mapped, input frame, input prot, input canCtrl,
                  input unlocked);
endinterface : pfd_dec_if
`default_nettype wire

// *** design/pfd_region_lookup.sv ***
// Purpose: Finds the frame and protection class of a word address.
// Assumes: Regions in the table never overlap.
// Notes:   Combinational; an address outside every region reports unmapped.
`timescale 1ns/100ps
`default_nettype none
module pfd_region_lookup (
  // Lookup port
  pfd_dec_if.lookup lookupPort
);

  logic [pfd_pkg::REGION_COUNT-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < pfd_pkg::REGION_COUNT; gi++) begin : g_region
      assign hit[gi] = (lookupPort.addr >= pfd_pkg::REGION_TABLE[gi].lo) &&
                       (lookupPort.addr <= pfd_pkg::REGION_TABLE[gi].hi);
    end
  endgenerate

  always_comb begin
    lookupPort.mapped  = 1'b0;
    lookupPort.frame   = pfd_pkg::FRAME_ZERO;
    lookupPort.prot    = pfd_pkg::PROT_NONE;
    lookupPort.canCtrl = 1'b0;
    for (int i = 0; i < pfd_pkg::REGION_COUNT; i++) begin
      if (hit[i]) begin
        lookupPort.mapped  = 1'b1;
        lookupPort.frame   = pfd_pkg::REGION_TABLE[i].frame;
        lookupPort.prot    = pfd_pkg::REGION_TABLE[i].prot;
        lookupPort.canCtrl = pfd_pkg::REGION_TABLE[i].canCtrl;
      end
    end
  end

endmodule : pfd_region_lookup
`default_nettype wire

// *** design/pfd_unlock_state.sv ***
// Purpose: Holds the write-unlock state set and cleared by core instructions.
// Assumes: Instruction strobes are one-cycle pulses from the core.
// Notes:   A lock and an unlock in the same cycle leave the state locked.
`timescale 1ns/100ps
`default_nettype none
module pfd_unlock_state (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  reset,
  // Instruction strobes
  input  wire logic  unlockInstr,
  input  wire logic  lockInstr,
  // State to the decoder
  pfd_dec_if.lock    lockPort
);

  logic unlocked_reg;

  // Locking wins a tie because a stray unlock is the greater hazard.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unlocked_reg <= 1'b0;
    end else if (lockInstr) begin
      unlocked_reg <= 1'b0;
    end else if (unlockInstr) begin
      unlocked_reg <= 1'b1;
    end
  end

  assign lockPort.unlocked = unlocked_reg;

endmodule : pfd_unlock_state
`default_nettype wire

// *** design/pfd_frame_decoder.sv ***
// Purpose: Decodes core accesses into three peripheral frames and gates writes.
// Assumes: One outstanding access; peripherals answer with an ack level.
// Notes:   Refused and dropped accesses complete without touching any frame.
// Operation
// - Protected writes dropped until unlock instruction.
// - Lock instruction re-blocks all protected writes.
// - Frame zero sits on core memory bus.
// - Frame zero takes 16- and 32-bit accesses.
// - Frame one uses 32-bit peripheral bus.
// - Frame two uses 16-bit peripheral bus.
// - Frame two refuses 32-bit accesses.
// - CAN control registers take 32-bit only.
// - Flash writes need unlock and security gate.
// - Security key words are unlock protected.
// - Dual-mapped converter results are unprotected.
// - Only chosen PWM registers are protected.
`timescale 1ns/100ps
`default_nettype none
module pfd_frame_decoder (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Core request
  input  wire logic                        coreReq,
  input  wire logic                        coreWrite,
  input  wire logic                        coreWide,
  input  wire logic [pfd_pkg::ADDR_W-1:0]  coreAddr,
  input  wire logic [pfd_pkg::DATA_W-1:0]  coreWdata,
  // Core answer
  output logic                             coreReady,
  output logic                             coreDone,
  output logic                             coreFault,
  output logic                             coreDropped,
  output logic [pfd_pkg::DATA_W-1:0]       coreRdata,
  // Protection controls
  input  wire logic                        unlockInstr,
  input  wire logic                        lockInstr,
  input  wire logic                        codeSecurityUnlocked,
  // Frame zero, core memory bus
  output logic                             f0Sel,
  output logic                             f0Write,
  output logic                             f0Wide,
  output logic [pfd_pkg::ADDR_W-1:0]       f0Addr,
  output logic [pfd_pkg::DATA_W-1:0]       f0Wdata,
  input  wire logic                        f0Ack,
  input  wire logic [pfd_pkg::DATA_W-1:0]  f0Rdata,
  // Frame one, 32-bit peripheral bus
  output logic                             f1Sel,
  output logic                             f1Write,
  output logic                             f1Wide,
  output logic [pfd_pkg::ADDR_W-1:0]       f1Addr,
  output logic [pfd_pkg::DATA_W-1:0]       f1Wdata,
  input  wire logic                        f1Ack,
  input  wire logic [pfd_pkg::DATA_W-1:0]  f1Rdata,
  // Frame two, 16-bit peripheral bus
  output logic                             f2Sel,
  output logic                             f2Write,
  output logic [pfd_pkg::ADDR_W-1:0]       f2Addr,
  output logic [pfd_pkg::HALF_W-1:0]       f2Wdata,
  input  wire logic                        f2Ack,
  input  wire logic [pfd_pkg::HALF_W-1:0]  f2Rdata
);

  pfd_dec_if decIf ();

  pfd_pkg::pfd_state_type             state_reg;
  logic                               coreReady_reg;
  logic                               coreDone_reg;
  logic                               coreFault_reg;
  logic                               coreDropped_reg;
  logic [pfd_pkg::DATA_W-1:0]         coreRdata_reg;
  logic                               f0Sel_reg;
  logic                               f0Write_reg;
  logic                               f0Wide_reg;
  logic [pfd_pkg::ADDR_W-1:0]         f0Addr_reg;
  logic [pfd_pkg::DATA_W-1:0]         f0Wdata_reg;
  logic                               f1Sel_reg;
  logic                               f1Write_reg;
  logic                               f1Wide_reg;
  logic [pfd_pkg::ADDR_W-1:0]         f1Addr_reg;
  logic [pfd_pkg::DATA_W-1:0]         f1Wdata_reg;
  logic                               f2Sel_reg;
  logic                               f2Write_reg;
  logic [pfd_pkg::ADDR_W-1:0]         f2Addr_reg;
  logic [pfd_pkg::HALF_W-1:0]         f2Wdata_reg;

  logic                               accept;
  logic                               misaligned;
  logic                               refuse;
  logic                               pwmWordProt;
  logic                               writeAllowed;
  logic                               dropWrite;
  logic                               forward;
  logic                               ackSeen;
  logic [pfd_pkg::DATA_W-1:0]         ackData;

  pfd_region_lookup uLookup (
    .lookupPort (decIf.lookup)
  );

  pfd_unlock_state uUnlock (
    .mclk        (mclk),
    .reset       (reset),
    .unlockInstr (unlockInstr),
    .lockInstr   (lockInstr),
    .lockPort    (decIf.lock)
  );

  // The unlock state stays inside the block; no port shows it to software.
  assign decIf.addr = coreAddr;
  assign accept     = coreReq && coreReady_reg;

  // Classify the access on the cycle it is taken.
  always_comb begin
    misaligned   = coreWide && coreAddr[0];
    refuse       = !decIf.mapped;
    if (misaligned) begin
      refuse = 1'b1;
    end
    if (decIf.frame == pfd_pkg::FRAME_TWO && coreWide) begin
      refuse = 1'b1;
    end
    if (decIf.canCtrl && !coreWide) begin
      refuse = 1'b1;
    end
    pwmWordProt  = pfd_pkg::PWM_PROT_MASK[coreAddr[pfd_pkg::PWM_OFS_BITS-1:0]];
    case (decIf.prot)
      pfd_pkg::PROT_NONE: begin
        writeAllowed = 1'b1;
      end
      pfd_pkg::PROT_UNLOCK: begin
        writeAllowed = decIf.unlocked;
      end
      pfd_pkg::PROT_FLASH: begin
        writeAllowed = decIf.unlocked && codeSecurityUnlocked;
      end
      pfd_pkg::PROT_PWM: begin
        writeAllowed = !pwmWordProt || decIf.unlocked;
      end
      default: begin
        writeAllowed = 1'b0;
      end
    endcase
    // Refusal wins over dropping, so a faulted write never reports a drop.
    dropWrite    = coreWrite && !writeAllowed && !refuse;
    forward      = !refuse && !dropWrite;
  end

  // Answer from whichever frame is selected; narrow reads clear the top half.
  always_comb begin
    ackSeen = 1'b0;
    ackData = pfd_pkg::DATA_ZERO;
    if (f0Sel_reg && f0Ack) begin
      ackSeen = 1'b1;
      ackData = f0Wide_reg ? f0Rdata : {pfd_pkg::HALF_ZERO, f0Rdata[pfd_pkg::HALF_W-1:0]};
    end else if (f1Sel_reg && f1Ack) begin
      ackSeen = 1'b1;
      ackData = f1Wide_reg ? f1Rdata : {pfd_pkg::HALF_ZERO, f1Rdata[pfd_pkg::HALF_W-1:0]};
    end else if (f2Sel_reg && f2Ack) begin
      ackSeen = 1'b1;
      ackData = {pfd_pkg::HALF_ZERO, f2Rdata};
    end
  end

  // Sequencer: one access in flight, so frames never see overlapping selects.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg     <= pfd_pkg::ST_IDLE;
      coreReady_reg <= 1'b1;
    end else begin
      case (state_reg)
        pfd_pkg::ST_IDLE: begin
          if (accept) begin
            coreReady_reg <= 1'b0;
            if (forward) begin
              state_reg <= pfd_pkg::ST_WAIT;
            end
          end else begin
            coreReady_reg <= 1'b1;
          end
        end
        pfd_pkg::ST_WAIT: begin
          if (ackSeen) begin
            state_reg     <= pfd_pkg::ST_IDLE;
            coreReady_reg <= 1'b1;
          end
        end
        default: begin
          state_reg     <= pfd_pkg::ST_IDLE;
          coreReady_reg <= 1'b1;
        end
      endcase
    end
  end

  // Completion status toward the core.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      coreDone_reg    <= 1'b0;
      coreFault_reg   <= 1'b0;
      coreDropped_reg <= 1'b0;
      coreRdata_reg   <= pfd_pkg::DATA_ZERO;
    // Refused and dropped accesses answer on the next edge with zero data.
    end else if (accept && !forward) begin
      coreDone_reg    <= 1'b1;
      coreFault_reg   <= refuse;
      coreDropped_reg <= dropWrite;
      coreRdata_reg   <= pfd_pkg::DATA_ZERO;
    end else if (state_reg == pfd_pkg::ST_WAIT && ackSeen) begin
      coreDone_reg    <= 1'b1;
      coreFault_reg   <= 1'b0;
      coreDropped_reg <= 1'b0;
      coreRdata_reg   <= ackData;
    end else begin
      coreDone_reg    <= 1'b0;
      coreFault_reg   <= 1'b0;
      coreDropped_reg <= 1'b0;
    end
  end

  // Frame zero goes straight onto the core memory bus at either width.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      f0Sel_reg   <= 1'b0;
      f0Write_reg <= 1'b0;
      f0Wide_reg  <= 1'b0;
      f0Addr_reg  <= '0;
      f0Wdata_reg <= pfd_pkg::DATA_ZERO;
    end else if (accept && forward && decIf.frame == pfd_pkg::FRAME_ZERO) begin
      f0Sel_reg   <= 1'b1;
      f0Write_reg <= coreWrite;
      f0Wide_reg  <= coreWide;
      f0Addr_reg  <= coreAddr;
      f0Wdata_reg <= coreWdata;
    end else if (f0Sel_reg && f0Ack) begin
      f0Sel_reg   <= 1'b0;
    end
  end

  // Frame one carries half and full words on the wide peripheral bus.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      f1Sel_reg   <= 1'b0;
      f1Write_reg <= 1'b0;
      f1Wide_reg  <= 1'b0;
      f1Addr_reg  <= '0;
      f1Wdata_reg <= pfd_pkg::DATA_ZERO;
    end else if (accept && forward && decIf.frame == pfd_pkg::FRAME_ONE) begin
      f1Sel_reg   <= 1'b1;
      f1Write_reg <= coreWrite;
      f1Wide_reg  <= coreWide;
      f1Addr_reg  <= coreAddr;
      f1Wdata_reg <= coreWdata;
    end else if (f1Sel_reg && f1Ack) begin
      f1Sel_reg   <= 1'b0;
    end
  end

  // Frame two only ever sees half words; wide accesses were refused earlier.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      f2Sel_reg   <= 1'b0;
      f2Write_reg <= 1'b0;
      f2Addr_reg  <= '0;
      f2Wdata_reg <= pfd_pkg::HALF_ZERO;
    end else if (accept && forward && decIf.frame == pfd_pkg::FRAME_TWO) begin
      f2Sel_reg   <= 1'b1;
      f2Write_reg <= coreWrite;
      f2Addr_reg  <= coreAddr;
      f2Wdata_reg <= coreWdata[pfd_pkg::HALF_W-1:0];
    end else if (f2Sel_reg && f2Ack) begin
      f2Sel_reg   <= 1'b0;
    end
  end

  assign coreReady   = coreReady_reg;
  assign coreDone    = coreDone_reg;
  assign coreFault   = coreFault_reg;
  assign coreDropped = coreDropped_reg;
  assign coreRdata   = coreRdata_reg;
  assign f0Sel       = f0Sel_reg;
  assign f0Write     = f0Write_reg;
  assign f0Wide      = f0Wide_reg;
  assign f0Addr      = f0Addr_reg;
  assign f0Wdata     = f0Wdata_reg;
  assign f1Sel       = f1Sel_reg;
  assign f1Write     = f1Write_reg;
  assign f1Wide      = f1Wide_reg;
  assign f1Addr      = f1Addr_reg;
  assign f1Wdata     = f1Wdata_reg;
  assign f2Sel       = f2Sel_reg;
  assign f2Write     = f2Write_reg;
  assign f2Addr      = f2Addr_reg;
  assign f2Wdata     = f2Wdata_reg;

endmodule : pfd_frame_decoder
`default_nettype wire

// *** sim/pfd_periph_model.sv ***
// Purpose: Behavioural peripheral that answers one frame bus of the decoder.
// Assumes: Select stays high until the acknowledge has been sampled.
// Notes:   Read data is a pattern of the address so the bench can predict it.
`timescale 1ns/100ps
`default_nettype none
module pfd_periph_model #(
  parameter int W = 32
) (
  // Clock
  input  wire logic          mclk,
  // Frame bus
  input  wire logic          sel,
  input  wire logic          write,
  input  wire logic [15:0]   addr,
  input  wire logic [W-1:0]  wdata,
  output logic               ack,
  output logic [W-1:0]       rdata,
  // Bench controls
  input  wire logic [3:0]    waitN,
  output logic [W-1:0]       lastW
);
  logic [3:0]   waitCnt = 4'h0;
  logic [W-1:0] pat;

  assign pat = W'({~addr, addr});
  // Stalls waitN cycles, so both prompt and slow answers are exercised.
  assign ack = sel && (waitCnt >= waitN);
  // A released bus shows the inverse pattern, so stale data never looks valid.
  assign rdata = ack ? pat : ~pat;

  always_ff @(posedge mclk) begin
    waitCnt <= (sel && !ack) ? waitCnt + 4'h1 : 4'h0;
    if (sel && ack && write) begin
      lastW <= wdata;
    end
  end
endmodule : pfd_periph_model
`default_nettype wire

// *** sim/pfd_frame_decoder_asserts.sv ***
// Purpose: Concurrent checks on the ports of the frame decoder.
// Assumes: Unlock state mirrored from the instruction strobes, lock wins.
// Notes:   Bound to every instance of the decoder.
`timescale 1ns/100ps
`default_nettype none
module pfd_frame_decoder_asserts (
  // Clock and reset
  input wire logic                        mclk,
  input wire logic                        reset,
  // Core side
  input wire logic                        coreReq,
  input wire logic                        coreWrite,
  input wire logic                        coreWide,
  input wire logic [pfd_pkg::ADDR_W-1:0]  coreAddr,
  input wire logic                        coreReady,
  input wire logic                        coreDone,
  input wire logic                        coreFault,
  input wire logic                        coreDropped,
  // Protection controls
  input wire logic                        unlockInstr,
  input wire logic                        lockInstr,
  input wire logic                        codeSecurityUnlocked,
  // Frame buses
  input wire logic                        f0Sel,
  input wire logic                        f0Wide,
  input wire logic                        f0Ack,
  input wire logic                        f1Sel,
  input wire logic                        f1Ack,
  input wire logic [pfd_pkg::ADDR_W-1:0]  f1Addr,
  input wire logic                        f2Sel,
  input wire logic                        f2Ack,
  input wire logic [pfd_pkg::ADDR_W-1:0]  f2Addr
);
  logic unl;
  logic taken, wr, prot, flash, pwm, canCtl;

  function automatic logic inr(input logic [15:0] a, input logic [15:0] lo,
                               input logic [15:0] hi);
    return a >= lo && a <= hi;
  endfunction : inr

  assign taken = coreReq && coreReady;
  assign wr = taken && coreWrite && !coreWide;
  assign prot = inr(coreAddr, 16'h0880, 16'h09ff) || inr(coreAddr, 16'h0ae0, 16'h0aef)
             || inr(coreAddr, 16'h0d00, 16'h0dff) || inr(coreAddr, 16'h7010, 16'h702f);
  assign flash = inr(coreAddr, 16'h0a80, 16'h0adf);
  assign pwm = inr(coreAddr, 16'h6800, 16'h697f);
  assign canCtl = inr(coreAddr, 16'h6000, 16'h60ff) || inr(coreAddr, 16'h6200, 16'h62ff);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unl <= 1'b0;
    end else if (lockInstr) begin
      unl <= 1'b0;
    end else if (unlockInstr) begin
      unl <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_locked_drop: assert property (wr && prot && !unl
    |=> coreDone && coreDropped) else $error("protected write passed while locked");
  a_unlock_pass: assert property (wr && prot && unl |=> !coreDone && (f0Sel || f2Sel))
    else $error("unlocked protected write not forwarded");
  a_flash_gate: assert property (wr && flash |-> if (unl && codeSecurityUnlocked)
    ##1 f0Sel else ##1 coreDropped) else $error("flash write gating wrong");
  a_adc_copy: assert property (wr && inr(coreAddr, 16'h0b00, 16'h0b0f) |=> f0Sel)
    else $error("converter copy write blocked");
  a_pwm_subset: assert property (wr && pwm && !unl
    |-> if (pfd_pkg::PWM_PROT_MASK[coreAddr[5:0]]) ##1 coreDropped else ##1 f1Sel)
    else $error("pwm protection subset wrong");
  a_f2_wide: assert property (taken && coreWide && inr(coreAddr, 16'h7000, 16'h7fff)
    |=> coreDone && coreFault) else $error("wide access to frame two accepted");
  a_can_narrow: assert property (taken && !coreWide && canCtl |=> coreDone && coreFault)
    else $error("narrow can control access accepted");
  a_f0_both: assert property (taken && !coreAddr[0]
    && inr(coreAddr, 16'h0c00, 16'h0c3f) |=> f0Sel && f0Wide == $past(coreWide))
    else $error("frame zero width not forwarded");
  a_f1_window: assert property ($rose(f1Sel) |-> inr(f1Addr, 16'h6000, 16'h6fff))
    else $error("frame one selected outside its range");
  a_f2_route: assert property ($rose(f2Sel) |-> inr(f2Addr, 16'h7000, 16'h7fff))
    else $error("frame two selected outside its range");
  a_ack_done: assert property ((f0Sel && f0Ack) || (f1Sel && f1Ack)
    || (f2Sel && f2Ack) |=> coreDone && coreReady && !coreFault)
    else $error("ack did not finish access");
endmodule : pfd_frame_decoder_asserts
bind pfd_frame_decoder pfd_frame_decoder_asserts u_chk (.mclk, .reset, .coreReq, .coreWrite,
  .coreWide, .coreAddr, .coreReady, .coreDone, .coreFault, .coreDropped, .unlockInstr,
  .lockInstr, .codeSecurityUnlocked, .f0Sel, .f0Wide, .f0Ack, .f1Sel, .f1Ack, .f1Addr,
  .f2Sel, .f2Ack, .f2Addr);
`default_nettype wire

// *** sim/pfd_frame_decoder_tb_top.sv ***
// Purpose: Self-checking bench for the peripheral frame decoder.
// Assumes: One access in flight; inputs change on the falling edge.
// Notes:   Expectations are queued by the driver and popped at each done.
`timescale 1ns/100ps
`default_nettype none
module pfd_frame_decoder_tb_top;
  typedef struct {logic f; logic d; logic rd; logic [31:0] v;} pfd_exp_type;

  logic        mclk, reset, coreReq, coreWrite, coreWide, unlockInstr, lockInstr, gateOpen;
  logic        coreReady, coreDone, coreFault, coreDropped;
  logic        f0Sel, f0Write, f0Wide, f0Ack, f1Sel, f1Write, f1Wide, f1Ack;
  logic        f2Sel, f2Write, f2Ack;
  logic [15:0] coreAddr, f0Addr, f1Addr, f2Addr, f2Wdata, f2Rdata, f2Last, lf;
  logic [31:0] coreWdata, coreRdata, f0Wdata, f0Rdata, f1Wdata, f1Rdata, f1Last, wdat;
  logic [3:0]  slow;
  pfd_exp_type expQ[$];
  pfd_exp_type mon;
  int          n_errors = 0;
  int          tests_run = 0;

  pfd_frame_decoder dut (.mclk, .reset, .coreReq, .coreWrite, .coreWide, .coreAddr,
    .coreWdata, .coreReady, .coreDone, .coreFault, .coreDropped, .coreRdata, .unlockInstr,
    .lockInstr, .codeSecurityUnlocked(gateOpen), .f0Sel, .f0Write,
    .f0Wide, .f0Addr, .f0Wdata, .f0Ack, .f0Rdata, .f1Sel, .f1Write, .f1Wide, .f1Addr,
    .f1Wdata, .f1Ack, .f1Rdata, .f2Sel, .f2Write, .f2Addr, .f2Wdata, .f2Ack, .f2Rdata);
  pfd_periph_model #(.W(32)) m0 (.mclk, .sel(f0Sel), .write(f0Write), .addr(f0Addr),
    .wdata(f0Wdata), .ack(f0Ack), .rdata(f0Rdata), .waitN(slow), .lastW());
  pfd_periph_model #(.W(32)) m1 (.mclk, .sel(f1Sel), .write(f1Write), .addr(f1Addr),
    .wdata(f1Wdata), .ack(f1Ack), .rdata(f1Rdata), .waitN(slow), .lastW(f1Last));
  pfd_periph_model #(.W(16)) m2 (.mclk, .sel(f2Sel), .write(f2Write), .addr(f2Addr),
    .wdata(f2Wdata), .ack(f2Ack), .rdata(f2Rdata), .waitN(slow), .lastW(f2Last));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Entered at a falling edge with the decoder ready; returns at a falling edge.
  task automatic acc(input logic wr, input logic wide, input logic [15:0] a,
                     input logic f, input logic d);
    int n;
    lf = lfsr_next(lf);
    wdat = {~lf, lf};
    expQ.push_back('{f, d, !wr || f || d, (f || d) ? 32'h0 : (wide ? {~a, a} : {16'h0, a})});
    coreReq <= 1'b1;
    coreWrite <= wr;
    coreWide <= wide;
    coreAddr <= a;
    coreWdata <= wdat;
    @(negedge mclk);
    coreReq <= 1'b0;
    n = 0;
    while (coreReady !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) chk("ready timeout", 32'h1, 32'h0);
  endtask : acc

  task automatic pulse(input logic u, input logic l);
    unlockInstr <= u;
    lockInstr <= l;
    @(negedge mclk);
    unlockInstr <= 1'b0;
    lockInstr <= 1'b0;
  endtask : pulse

  always @(negedge mclk) begin
    if (coreDone === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected done", 32'h1, 32'h0);
      else begin
        mon = expQ.pop_front();
        chk("fault", {31'h0, coreFault}, {31'h0, mon.f});
        chk("dropped", {31'h0, coreDropped}, {31'h0, mon.d});
        if (mon.rd) chk("read data", coreRdata, mon.v);
      end
    end
  end

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Expected run is a few hundred cycles; this leaves ample margin.
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    {reset, coreReq, coreWrite, coreWide, unlockInstr, lockInstr, gateOpen} = 7'h40;
    coreAddr = 16'h0000;
    coreWdata = 32'h0;
    slow = 4'h0;
    lf = 16'h001d;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk("ready after reset", {31'h0, coreReady}, 32'h1);
    acc(1, 0, 16'h0ae5, 0, 1);
    acc(1, 0, 16'h7010, 0, 1);
    acc(1, 0, 16'h0d10, 0, 1);
    acc(1, 0, 16'h0b03, 0, 0);
    for (int i = 0; i < 6; i++) begin
      acc(1, 0, 16'h6800 + 16'(i * 64) + {10'h0, 2'b11, lf[3:0]}, 0, 1);
      acc(1, 0, 16'h6800 + 16'(i * 64) + {10'h0, 1'b0, lf[4:0]}, 0, 0);
    end
    $display("test locked regions done");
    pulse(1, 0);
    acc(1, 0, 16'h0ae5, 0, 0);
    acc(1, 0, 16'h7010, 0, 0);
    chk("frame two write data", {16'h0, f2Last}, {16'h0, wdat[15:0]});
    acc(1, 0, 16'h0a90, 0, 1);
    gateOpen <= 1'b1;
    acc(1, 0, 16'h0a90, 0, 0);
    pulse(1, 1);
    acc(1, 0, 16'h0ae5, 0, 1);
    acc(1, 0, 16'h0a90, 0, 1);
    $display("test unlock and lock done");
    for (int i = 0; i < 8; i++) begin
      slow <= {2'b00, lf[1:0]};
      acc(0, 1, {10'h030, lf[4:0], 1'b0}, 0, 0);
      acc(0, 0, {10'h030, lf[5:0]}, 0, 0);
      acc(0, 1, {11'h350, lf[3:0], 1'b0}, 0, 0);
      acc(0, 0, {12'h704, lf[3:0]}, 0, 0);
      acc(0, 1, 16'h6004, 0, 0);
    end
    $display("test reads done");
    acc(0, 1, 16'h7042, 1, 0);
    acc(1, 1, 16'h7042, 1, 0);
    acc(0, 0, 16'h6004, 1, 0);
    acc(1, 1, 16'h6001, 1, 0);
    acc(0, 0, 16'h0a00, 1, 0);
    acc(1, 1, 16'h6a02, 0, 0);
    @(negedge mclk);
    chk("frame one write data", f1Last, wdat);
    chk("pending results", 32'(expQ.size()), 32'h0);
    $display("test faults done");
    print_verdict();
  end
endmodule : pfd_frame_decoder_tb_top
`default_nettype wire
